// *** rtl/dps_regs.sv ***
// Discharge over-current and step-down regulator configuration registers
//
// Summary of operation
// - Three-bit threshold, 0.55-1.75 A, 7 reserved
// - Bit 1 keeps protection in high-impedance
// - Bit 0 enables protection, default set
// - Bit 7 turns step-down on, default off
// - Range writable when off or enable cleared
// - Range bit: low 0.6-1.3, high 1.3-2.1
// - Voltage code 0.60 V plus 50 mV steps
// - Bit 5 set disables off-time pull-down
`timescale 1ns/10ps
`default_nettype none
`include "dps_map.svh"

module dps_regs (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              nrst_i,
   // Register port
   input  wire logic [7:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [7:0]        rdata_o,
   // Settings to the analog side
   output dps_pkg::dps_guard_t    guard_o,
   output dps_pkg::dps_buck_t     buck_o
);

   // ==========================================================
   // Checks
   function automatic logic volt_ok(input logic [4:0] code,
                                    input logic       hi);
      if (code == `DPS_VOUT_RSVD)
         volt_ok = 1'b0;
      else if (hi)
         volt_ok = (code >= `DPS_VOUT_HIGH_MIN) &&
                   (code <= `DPS_VOUT_HIGH_MAX);
      else
         volt_ok = (code <= `DPS_VOUT_LOW_MAX);
   endfunction : volt_ok

   // ==========================================================
   // State
   dps_pkg::dps_state_t st_reg;
   dps_pkg::dps_state_t st_next;
   dps_pkg::dps_guard_t guard_reg;
   dps_pkg::dps_guard_t guard_next;
   dps_pkg::dps_buck_t  buck_reg;
   dps_pkg::dps_buck_t  buck_next;

   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      st_next = st_reg;
      st_next.rdata_reg = 8'h00;
      if (wr_i) begin
         unique case (addr_i)
            `DPS_ADDR_LIMIT: begin
               st_next.limit_reg = wdata_i & `DPS_LIMIT_MASK;
            end
            `DPS_ADDR_BUCK: begin
               b = wdata_i & `DPS_BUCK_MASK;
               if (st_reg.buck_reg[`DPS_EN_BIT] && b[`DPS_EN_BIT])
                  b[`DPS_RANGE_BIT] =
                     st_reg.buck_reg[`DPS_RANGE_BIT];
               st_next.buck_reg = b;
            end
            `DPS_ADDR_BUCK_CFG: begin
               st_next.cfg_reg = wdata_i & `DPS_CFG_MASK;
            end
            default: begin
            end
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            `DPS_ADDR_LIMIT:    st_next.rdata_reg = st_reg.limit_reg;
            `DPS_ADDR_BUCK:     st_next.rdata_reg = st_reg.buck_reg;
            `DPS_ADDR_BUCK_CFG: st_next.rdata_reg = st_reg.cfg_reg;
            default:            st_next.rdata_reg = 8'h00;
         endcase
      end
      guard_next.discharge_overcurrent_level =
         st_next.limit_reg[`DPS_LVL_LSB +: 3];
      guard_next.overcurrent_guard_in_highz =
         st_next.limit_reg[`DPS_HIZ_BIT];
      guard_next.discharge_overcurrent_guard_on =
         st_next.limit_reg[`DPS_GUARD_BIT];
      guard_next.level_valid =
         (st_next.limit_reg[`DPS_LVL_LSB +: 3] != `DPS_LVL_RSVD);
      buck_next.stepdown_on = st_next.buck_reg[`DPS_EN_BIT];
      buck_next.stepdown_upper_range_select =
         st_next.buck_reg[`DPS_RANGE_BIT];
      buck_next.stepdown_output_voltage = st_next.buck_reg[4:0];
      buck_next.stepdown_off_pulldown_disable =
         st_next.cfg_reg[`DPS_PD_BIT];
      buck_next.stepdown_peak_limit_offset = st_next.cfg_reg[1:0];
      buck_next.voltage_valid = volt_ok(st_next.buck_reg[4:0],
                                        st_next.buck_reg[`DPS_RANGE_BIT]);
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg    <= {`DPS_RST_LIMIT, `DPS_RST_BUCK,
                       `DPS_RST_BUCK_CFG, 8'h00};
         guard_reg <= {3'h3, 1'b0, 1'b1, 1'b1};
         buck_reg  <= {1'b0, 1'b1, 5'h1c, 1'b0, 2'h0, 1'b1};
      end else begin
         st_reg    <= st_next;
         guard_reg <= guard_next;
         buck_reg  <= buck_next;
      end
   end

   // ==========================================================
   // Outputs
   assign rdata_o = st_reg.rdata_reg;
   assign guard_o = guard_reg;
   assign buck_o  = buck_reg;

endmodule : dps_regs
`default_nettype wire

// *** rtl/dps_map.svh ***
// Register offsets, field positions and reset values of the register bank
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_ADDR_LIMIT        8'h29
`define DPS_ADDR_BUCK         8'h30
`define DPS_ADDR_BUCK_CFG     8'h31
`define DPS_RST_LIMIT         8'h0d
`define DPS_RST_BUCK          8'h5c
`define DPS_RST_BUCK_CFG      8'h00
`define DPS_LIMIT_MASK        8'h1f
`define DPS_BUCK_MASK         8'hdf
`define DPS_CFG_MASK          8'h23
`define DPS_LVL_LSB           2
`define DPS_LVL_RSVD          3'h7
`define DPS_HIZ_BIT           1
`define DPS_GUARD_BIT         0
`define DPS_EN_BIT            7
`define DPS_RANGE_BIT         6
`define DPS_PD_BIT            5
`define DPS_VOUT_RSVD         5'h1f
`define DPS_VOUT_LOW_MAX      5'h0e
`define DPS_VOUT_HIGH_MIN     5'h0e
`define DPS_VOUT_HIGH_MAX     5'h1e
`endif

// *** rtl/dps_pkg.sv ***
// Types of the discharge-protect and step-down register bank
package dps_pkg;
   typedef struct packed {
      logic [7:0] limit_reg;
      logic [7:0] buck_reg;
      logic [7:0] cfg_reg;
      logic [7:0] rdata_reg;
   } dps_state_t;

   typedef struct packed {
      logic [2:0] discharge_overcurrent_level;
      logic       overcurrent_guard_in_highz;
      logic       discharge_overcurrent_guard_on;
      logic       level_valid;
   } dps_guard_t;

   typedef struct packed {
      logic       stepdown_on;
      logic       stepdown_upper_range_select;
      logic [4:0] stepdown_output_voltage;
      logic       stepdown_off_pulldown_disable;
      logic [1:0] stepdown_peak_limit_offset;
      logic       voltage_valid;
   } dps_buck_t;
endpackage : dps_pkg

// *** verif/dps_regs_properties.sv ***
// Port relations of the register bank
`timescale 1ns/10ps
`default_nettype none
module dps_regs_chk (
   // Clock, reset, register port
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Settings
   input wire dps_pkg::dps_guard_t guard_o,
   input wire dps_pkg::dps_buck_t buck_o
);
   wire logic w29 = wr_i && addr_i == 8'h29;
   wire logic w30 = wr_i && addr_i == 8'h30;
   wire logic lk = buck_o.stepdown_on && wdata_i[7];
   wire logic [4:0] v = buck_o.stepdown_output_voltage;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   chk_level_write: assert property (w29 |=>
      guard_o.discharge_overcurrent_level == $past(wdata_i[4:2])) else $error("level");
   chk_guard_write: assert property (w29 |=>
      {guard_o.overcurrent_guard_in_highz, guard_o.discharge_overcurrent_guard_on}
      == $past(wdata_i[1:0])) else $error("guard bits");
   chk_buck_on: assert property (w30 |=>
      buck_o.stepdown_on == $past(wdata_i[7])) else $error("enable");
   chk_range_lock: assert property (w30 && lk |=>
      $stable(buck_o.stepdown_upper_range_select)) else $error("range lock");
   chk_range_write: assert property (w30 && !lk |=>
      buck_o.stepdown_upper_range_select == $past(wdata_i[6])) else $error("range");
   chk_volt_write: assert property (w30 |=>
      v == $past(wdata_i[4:0])) else $error("voltage");
   chk_volt_valid: assert property (buck_o.voltage_valid ==
      (buck_o.stepdown_upper_range_select ? v >= 5'h0e && v <= 5'h1e : v <= 5'h0e))
      else $error("voltage flag");
   chk_pd_write: assert property (wr_i && addr_i == 8'h31 |=>
      buck_o.stepdown_off_pulldown_disable == $past(wdata_i[5])) else $error("pd");
endmodule : dps_regs_chk
`default_nettype wire

// *** verif/tb_top.sv ***
// Random and corner tests of the register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic core_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, m29 = 8'h0d, m30 = 8'h5c, m31 = 0;
   logic [7:0] ad [4] = '{8'h29, 8'h30, 8'h31, 8'h2a};
   logic [7:0] mk [4] = '{8'h1f, 8'hdf, 8'h23, 8'hff};
   logic [15:0] cw [5] = '{16'h30c0, 16'h3080, 16'h3000, 16'h291f, 16'h2aff};
   logic [31:0] s = 32'h0000_22d0;
   logic [7:0] d;
   dps_pkg::dps_guard_t guard_o;
   dps_pkg::dps_buck_t buck_o;
   int mismatches = 0, total_checks = 0, cyc = 0;
   dps_regs u_dut (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .guard_o, .buck_o);
   always #20 core_clk_i = ~core_clk_i;
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return a == 8'h29 ? m29 : a == 8'h30 ? m30 : a == 8'h31 ? m31 : 8'h00;
   endfunction : exp_rd
   function automatic logic vok(input logic [4:0] c, input logic hi);
      if (c == 5'h1f) return 1'b0;
      return hi ? (c >= 5'h0e && c <= 5'h1e) : (c <= 5'h0e);
   endfunction : vok
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic check(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, d);
      @(posedge core_clk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1;
      @(posedge core_clk_i);
      wr_i <= 0;
      if (a == 8'h29) m29 = d & 8'h1f;
      if (a == 8'h30) m30 = {d[7], m30[7] & d[7] ? m30[6] : d[6], 1'b0, d[4:0]};
      if (a == 8'h31) m31 = d & 8'h23;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_i);
      addr_i <= a; rd_i <= 1;
      @(posedge core_clk_i);
      rd_i <= 0;
      #1 check(rdata_o, exp_rd(a));
      check(guard_o, {m29[4:2], m29[1:0], m29[4:2] != 3'h7});
      check(buck_o, {m30[7:6], m30[4:0], m31[5], m31[1:0],
         vok(m30[4:0], m30[6])});
   endtask : rd
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         report_and_stop;
      end
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      nrst_i <= 1;
      foreach (ad[i]) rd(ad[i]);
      foreach (cw[i]) begin
         wr(cw[i][15:8], cw[i][7:0]);
         rd(cw[i][15:8]);
      end
      repeat (80) begin
         s = xs(s);
         d = s[15:8] & mk[s[1:0]];
         if (ad[s[1:0]] == 8'h29 && d[4:2] == 3'h7) d[4] = 1'b0;
         if (ad[s[1:0]] == 8'h30 && d[4:0] == 5'h1f) d[0] = 1'b0;
         wr(ad[s[1:0]], d);
         rd(ad[s[3:2]]);
      end
      report_and_stop;
   end
endmodule : tb_top
bind dps_regs dps_regs_chk u_chk (.core_clk_i, .nrst_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .rdata_o, .guard_o, .buck_o);
`default_nettype wire
